// ==== verilog/rhpc_pkg.sv ====
// root hub port change flags: shared constants, offsets and types
// assumes a 40 MHz aclk and an AXI4-Lite master on the register side
// How it works
// - reset done flag bit 20 after 10 ms
// - overcurrent change bit 19 on indicator change
// - overcurrent change only valid in per-port mode
// - resume done bit 18 after pulse, EOP, 3 ms
// - reset done setting clears resume done flag
// - write one clears flag, zero ignored
// - enable lost only on hardware disable
// - connect change on plug events, bad commands
package rhpc_pkg;

  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned RESET_TIME_US  = 10000;
  localparam int unsigned RESUME_TIME_US = 20000;
  localparam int unsigned RESYNC_TIME_US = 3000;
  localparam int unsigned EOP_TIME_NS    = 1334;

  localparam int unsigned RESET_CYCLES  = RESET_TIME_US * CLK_MHZ;
  localparam int unsigned RESUME_CYCLES = RESUME_TIME_US * CLK_MHZ;
  localparam int unsigned RESYNC_CYCLES = RESYNC_TIME_US * CLK_MHZ;
  localparam int unsigned EOP_CYCLES    = (EOP_TIME_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned CNT_W  = 20;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SYNC_W = 3;

  typedef logic [CNT_W-1:0] rhpc_count_t;

  localparam logic [ADDR_W-1:0] STATUS_OFFSET  = 8'h00;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 8'h04;

  // status word, low half
  localparam int unsigned BIT_CONNECTED = 0;
  localparam int unsigned BIT_ENABLED   = 1;
  localparam int unsigned BIT_SUSPENDED = 2;
  localparam int unsigned BIT_OVERCUR   = 3;
  localparam int unsigned BIT_RESETTING = 4;
  // change flags start here; index 0..4 within the flag vector
  localparam int unsigned CHG_LSB       = 16;
  localparam int unsigned CHG_W         = 5;
  localparam int unsigned CHG_CONNECT   = 0;
  localparam int unsigned CHG_ENABLE    = 1;
  localparam int unsigned CHG_RESUME    = 2;
  localparam int unsigned CHG_OVERCUR   = 3;
  localparam int unsigned CHG_RESET     = 4;

  localparam int unsigned CTRL_PER_PORT = 0;
  localparam logic        CTRL_RESET    = 1'b1;
  localparam logic [CHG_W-1:0] CHG_RESET_VALUE = 5'h00;

  localparam int unsigned SYNC_PRESENT = 0;
  localparam int unsigned SYNC_OVERCUR = 1;
  localparam int unsigned SYNC_FAULT   = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    RHPC_IDLE   = 5'h01,
    RHPC_RESET  = 5'h02,
    RHPC_RESUME = 5'h04,
    RHPC_EOP    = 5'h08,
    RHPC_RESYNC = 5'h10
  } rhpc_phase_t;

endpackage

// ==== verilog/rhpc_sync.sv ====
// three-stage synchroniser for the port pins
// assumes asynchronous pin levels; output follows once stages 2 and 3 agree
`timescale 1ns/10ps
module rhpc_sync (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [rhpc_pkg::SYNC_W-1:0] pin_in,
  output logic      [rhpc_pkg::SYNC_W-1:0] pin_stable
);
  logic [rhpc_pkg::SYNC_W-1:0] stage1;
  logic [rhpc_pkg::SYNC_W-1:0] stage2;
  logic [rhpc_pkg::SYNC_W-1:0] stage3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_stable <= '0;
    end else begin
      for (int i = 0; i < rhpc_pkg::SYNC_W; i++) begin
        if (stage2[i] == stage3[i]) begin
          pin_stable[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// ==== verilog/rhpc_port.sv ====
// root hub port: status and change flags behind an AXI4-Lite slave
// assumes a single 40 MHz clock and asynchronous port pins
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module rhpc_port #(
  parameter int unsigned RESET_CYCLES  = rhpc_pkg::RESET_CYCLES,
  parameter int unsigned RESUME_CYCLES = rhpc_pkg::RESUME_CYCLES,
  parameter int unsigned RESYNC_CYCLES = rhpc_pkg::RESYNC_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [rhpc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [rhpc_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic                        dev_present_pin,
  input  wire logic                        overcurrent_pin,
  input  wire logic                        port_fault_pin,
  output logic                             port_reset_active,
  output logic                             resume_drive,
  output logic                             eop_drive,
  output logic                             port_enabled,
  output logic                             port_suspended
);

  logic [rhpc_pkg::SYNC_W-1:0]   pins;
  logic                          aw_held;
  logic [rhpc_pkg::ADDR_W-1:0]   aw_addr;
  logic                          w_held;
  logic [31:0]                   w_data;
  logic [3:0]                    w_strb;
  logic                          do_write;
  logic                          wr_status;
  logic                          wr_ctrl;
  logic                          per_port;
  logic                          connected;
  logic                          conn_q;
  logic                          connect_evt;
  logic                          fault;
  logic                          port_overcurrent_flag;
  logic                          oc_evt;
  logic                          cmd_clr_enable;
  logic                          cmd_set_enable;
  logic                          cmd_set_suspend;
  logic                          cmd_clr_suspend;
  logic                          cmd_set_reset;
  logic                          bad_cmd;
  logic                          hw_disable;
  logic [rhpc_pkg::CHG_W-1:0]    clr_mask;
  logic [rhpc_pkg::CHG_W-1:0]    set_mask;
  logic [rhpc_pkg::CHG_W-1:0]    chg;
  logic [rhpc_pkg::CHG_W-1:0]    next_chg;
  rhpc_pkg::rhpc_phase_t         phase;
  rhpc_pkg::rhpc_phase_t         next_phase;
  rhpc_pkg::rhpc_count_t         cnt;
  logic                          phase_end;
  logic                          reset_done;
  logic                          resume_done;

  function automatic rhpc_pkg::rhpc_count_t phase_limit(input rhpc_pkg::rhpc_phase_t p);
    case (p)
      rhpc_pkg::RHPC_RESET:  phase_limit = rhpc_pkg::rhpc_count_t'(RESET_CYCLES - 1);
      rhpc_pkg::RHPC_RESUME: phase_limit = rhpc_pkg::rhpc_count_t'(RESUME_CYCLES - 1);
      rhpc_pkg::RHPC_EOP:    phase_limit = rhpc_pkg::rhpc_count_t'(rhpc_pkg::EOP_CYCLES - 1);
      rhpc_pkg::RHPC_RESYNC: phase_limit = rhpc_pkg::rhpc_count_t'(RESYNC_CYCLES - 1);
      default:               phase_limit = '0;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input logic [rhpc_pkg::ADDR_W-1:0] a);
    read_word = 32'h0000_0000;
    if (a == rhpc_pkg::STATUS_OFFSET) begin
      read_word[rhpc_pkg::BIT_CONNECTED] = connected;
      read_word[rhpc_pkg::BIT_ENABLED]   = port_enabled;
      read_word[rhpc_pkg::BIT_SUSPENDED] = port_suspended;
      read_word[rhpc_pkg::BIT_OVERCUR]   = port_overcurrent_flag & per_port;
      read_word[rhpc_pkg::BIT_RESETTING] = port_reset_active;
      read_word[rhpc_pkg::CHG_LSB +: rhpc_pkg::CHG_W] = chg;
    end else if (a == rhpc_pkg::CONTROL_OFFSET) begin
      read_word[rhpc_pkg::CTRL_PER_PORT] = per_port;
    end
  endfunction

  function automatic logic is_mapped(input logic [rhpc_pkg::ADDR_W-1:0] a);
    is_mapped = (a == rhpc_pkg::STATUS_OFFSET) || (a == rhpc_pkg::CONTROL_OFFSET);
  endfunction

  rhpc_sync u_sync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin_in     ({port_fault_pin, overcurrent_pin, dev_present_pin}),
    .pin_stable (pins)
  );

  assign connected = pins[rhpc_pkg::SYNC_PRESENT];
  assign fault     = pins[rhpc_pkg::SYNC_FAULT];

  // write channel capture
  assign awready  = !aw_held;
  assign wready   = !w_held;
  assign do_write = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= rhpc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(aw_addr) ? rhpc_pkg::RESP_OKAY : rhpc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= rhpc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= read_word(araddr);
      rresp  <= is_mapped(araddr) ? rhpc_pkg::RESP_OKAY : rhpc_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // command decode
  assign wr_status       = do_write && (aw_addr == rhpc_pkg::STATUS_OFFSET);
  assign wr_ctrl         = do_write && (aw_addr == rhpc_pkg::CONTROL_OFFSET);
  assign cmd_clr_enable  = wr_status && w_strb[0] && w_data[rhpc_pkg::BIT_CONNECTED];
  assign cmd_set_enable  = wr_status && w_strb[0] && w_data[rhpc_pkg::BIT_ENABLED];
  assign cmd_set_suspend = wr_status && w_strb[0] && w_data[rhpc_pkg::BIT_SUSPENDED];
  assign cmd_clr_suspend = wr_status && w_strb[0] && w_data[rhpc_pkg::BIT_OVERCUR];
  assign cmd_set_reset   = wr_status && w_strb[0] && w_data[rhpc_pkg::BIT_RESETTING];
  assign bad_cmd         = !connected && (cmd_set_reset || cmd_set_enable || cmd_set_suspend);
  assign clr_mask        = (wr_status && w_strb[2]) ?
                           w_data[rhpc_pkg::CHG_LSB +: rhpc_pkg::CHG_W] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_port <= rhpc_pkg::CTRL_RESET;
    end else if (wr_ctrl && w_strb[0]) begin
      per_port <= w_data[rhpc_pkg::CTRL_PER_PORT];
    end
  end

  // pin history for event detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conn_q                <= 1'b0;
      port_overcurrent_flag <= 1'b0;
    end else begin
      conn_q                <= connected;
      port_overcurrent_flag <= pins[rhpc_pkg::SYNC_OVERCUR];
    end
  end

  assign connect_evt = connected != conn_q;
  assign oc_evt      = pins[rhpc_pkg::SYNC_OVERCUR] != port_overcurrent_flag;

  // reset and resume signalling sequencer
  assign phase_end   = cnt == phase_limit(phase);
  assign reset_done  = (phase == rhpc_pkg::RHPC_RESET) && phase_end && connected;
  assign resume_done = (phase == rhpc_pkg::RHPC_RESYNC) && phase_end && connected;

  always_comb begin
    next_phase = phase;
    case (phase)
      rhpc_pkg::RHPC_IDLE: begin
        if (cmd_set_reset && connected) begin
          next_phase = rhpc_pkg::RHPC_RESET;
        end else if (cmd_clr_suspend && port_suspended && connected) begin
          next_phase = rhpc_pkg::RHPC_RESUME;
        end
      end
      rhpc_pkg::RHPC_RESET: begin
        if (!connected || phase_end) begin
          next_phase = rhpc_pkg::RHPC_IDLE;
        end
      end
      rhpc_pkg::RHPC_RESUME: begin
        if (!connected) begin
          next_phase = rhpc_pkg::RHPC_IDLE;
        end else if (phase_end) begin
          next_phase = rhpc_pkg::RHPC_EOP;
        end
      end
      rhpc_pkg::RHPC_EOP: begin
        if (!connected) begin
          next_phase = rhpc_pkg::RHPC_IDLE;
        end else if (phase_end) begin
          next_phase = rhpc_pkg::RHPC_RESYNC;
        end
      end
      rhpc_pkg::RHPC_RESYNC: begin
        if (!connected || phase_end) begin
          next_phase = rhpc_pkg::RHPC_IDLE;
        end
      end
      default: next_phase = rhpc_pkg::RHPC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= rhpc_pkg::RHPC_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (next_phase != phase)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + rhpc_pkg::rhpc_count_t'(1);
    end
  end

  assign port_reset_active = phase == rhpc_pkg::RHPC_RESET;
  assign resume_drive      = phase == rhpc_pkg::RHPC_RESUME;
  assign eop_drive         = phase == rhpc_pkg::RHPC_EOP;

  // port enable and suspend state
  assign hw_disable = port_enabled && (!connected || fault);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_enabled <= 1'b0;
    end else if (!connected || fault) begin
      port_enabled <= 1'b0;
    end else if (reset_done || cmd_set_enable) begin
      port_enabled <= 1'b1;
    end else if (cmd_clr_enable) begin
      port_enabled <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_suspended <= 1'b0;
    end else if (!connected || resume_done || port_reset_active) begin
      port_suspended <= 1'b0;
    end else if (cmd_set_suspend && port_enabled && (phase == rhpc_pkg::RHPC_IDLE)) begin
      port_suspended <= 1'b1;
    end
  end

  // change flags: a set in the same cycle as a clear wins
  always_comb begin
    set_mask = '0;
    set_mask[rhpc_pkg::CHG_CONNECT] = connect_evt || bad_cmd;
    set_mask[rhpc_pkg::CHG_ENABLE]  = hw_disable;
    set_mask[rhpc_pkg::CHG_RESUME]  = resume_done;
    set_mask[rhpc_pkg::CHG_OVERCUR] = per_port && oc_evt;
    set_mask[rhpc_pkg::CHG_RESET]   = reset_done;
    next_chg = (chg & ~clr_mask) | set_mask;
    if (reset_done) begin
      next_chg[rhpc_pkg::CHG_RESUME] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg <= rhpc_pkg::CHG_RESET_VALUE;
    end else begin
      chg <= next_chg;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence eop_leave_s;
    (phase == rhpc_pkg::RHPC_EOP) && phase_end && connected;
  endsequence

  sequence resync_entry_s;
    (phase == rhpc_pkg::RHPC_RESYNC) && (cnt == '0);
  endsequence

  reset_done_flag_a: assert property (reset_done |=> chg[rhpc_pkg::CHG_RESET])
    else $error("reset done flag not set");
  reset_length_a: assert property ((phase == rhpc_pkg::RHPC_RESET) && (cnt == '0) && connected
    |-> !phase_end)
    else $error("port reset ended too early");
  oc_change_set_a: assert property (per_port && oc_evt |=> chg[rhpc_pkg::CHG_OVERCUR])
    else $error("overcurrent change not flagged");
  oc_global_quiet_a: assert property (!per_port && !chg[rhpc_pkg::CHG_OVERCUR]
    |=> !chg[rhpc_pkg::CHG_OVERCUR])
    else $error("overcurrent change set in global mode");
  resume_order_a: assert property (eop_leave_s |=> resync_entry_s)
    else $error("resync did not follow end of packet");
  resume_cause_a: assert property ($rose(chg[rhpc_pkg::CHG_RESUME])
    |-> $past(phase == rhpc_pkg::RHPC_RESYNC))
    else $error("resume done flag without resync");
  resume_cleared_a: assert property (reset_done |=> !chg[rhpc_pkg::CHG_RESUME])
    else $error("resume done not cleared by reset done");
  zero_write_keep_a: assert property (wr_status && !clr_mask[rhpc_pkg::CHG_RESET]
    && chg[rhpc_pkg::CHG_RESET] |=> chg[rhpc_pkg::CHG_RESET])
    else $error("zero write changed reset done flag");
  one_write_clear_a: assert property (clr_mask[rhpc_pkg::CHG_CONNECT] && !connect_evt
    && !bad_cmd |=> !chg[rhpc_pkg::CHG_CONNECT])
    else $error("write one did not clear connect change");
  enable_lost_a: assert property (cmd_clr_enable && connected && !fault
    && !chg[rhpc_pkg::CHG_ENABLE] |=> ##1 !chg[rhpc_pkg::CHG_ENABLE])
    else $error("driver disable set enable lost flag");
  connect_change_a: assert property (connect_evt |=> chg[rhpc_pkg::CHG_CONNECT])
    else $error("connect change not flagged");
  flags_after_reset_a: assert property (disable iff (1'b0)
    !aresetn |=> (chg == rhpc_pkg::CHG_RESET_VALUE))
    else $error("change flags not zero after reset");

endmodule

// ==== verification/rhpc_usb_dev.sv ====
// downstream device model: drives the port pins and times the port's drive pulses
// assumes bench requests change right after a rising aclk edge
`timescale 1ns/10ps
module rhpc_usb_dev (
  input  wire logic aclk,
  input  wire logic plug_req,
  input  wire logic oc_req,
  input  wire logic fault_req,
  input  wire logic port_reset_active,
  input  wire logic resume_drive,
  input  wire logic eop_drive,
  output logic      dev_present_pin,
  output logic      overcurrent_pin,
  output logic      port_fault_pin,
  output int        rst_len,
  output int        res_len,
  output int        eop_len,
  output int        n_ends
);
  logic [2:0] act;
  int         cnt [3];
  int         len [3];
  // pins follow the bench's plug, overcurrent and fault requests
  assign dev_present_pin = plug_req;
  assign overcurrent_pin = oc_req;
  assign port_fault_pin  = fault_req;
  assign act             = {eop_drive, resume_drive, port_reset_active};
  assign rst_len         = len[0];
  assign res_len         = len[1];
  assign eop_len         = len[2];
  initial begin
    n_ends = 0;
    for (int k = 0; k < 3; k++) begin
      cnt[k] = 0;
      len[k] = 0;
    end
  end
  // length of each drive pulse in aclk cycles, counted when it ends
  always @(posedge aclk) begin
    for (int k = 0; k < 3; k++) begin
      if (act[k] === 1'b1) begin
        cnt[k] <= cnt[k] + 1;
      end else if (cnt[k] != 0) begin
        len[k] <= cnt[k];
        cnt[k] <= 0;
        n_ends <= n_ends + 1;
      end
    end
  end
endmodule

// ==== verification/testbench.sv ====
// bench for the root hub port change flags over AXI4-Lite
// assumes shortened reset, resume and resync counts and the device model
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, port_reset_active, resume_drive;
  logic        eop_drive, port_enabled, port_suspended, plug_req, oc_req, fault_req;
  logic        dev_present_pin, overcurrent_pin, port_fault_pin;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          rst_len, res_len, eop_len, n_ends, fail_count, samples_checked, cycles;

  rhpc_port #(.RESET_CYCLES(40), .RESUME_CYCLES(30), .RESYNC_CYCLES(20)) u_rhpc_port (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dev_present_pin(dev_present_pin), .overcurrent_pin(overcurrent_pin),
    .port_fault_pin(port_fault_pin), .port_reset_active(port_reset_active),
    .resume_drive(resume_drive), .eop_drive(eop_drive), .port_enabled(port_enabled),
    .port_suspended(port_suspended));

  rhpc_usb_dev u_rhpc_usb_dev (
    .aclk(aclk), .plug_req(plug_req), .oc_req(oc_req), .fault_req(fault_req),
    .port_reset_active(port_reset_active), .resume_drive(resume_drive),
    .eop_drive(eop_drive), .dev_present_pin(dev_present_pin),
    .overcurrent_pin(overcurrent_pin), .port_fault_pin(port_fault_pin),
    .rst_len(rst_len), .res_len(res_len), .eop_len(eop_len), .n_ends(n_ends));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      close_out();
    end
  end

  // one write; each handshake is sampled and released at the same rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        tb = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    `CHK(r, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        tr = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    `CHK(d, ed)
    `CHK(r, er)
  endtask

  task automatic wait_end(input int n);
    int start;
    int i;
    start = n_ends;
    i = 0;
    while (n_ends < start + n && i < 400) begin
      @(posedge aclk);
      i++;
    end
  endtask

  task automatic pins(input logic p, input logic o, input logic f);
    @(posedge aclk);
    plug_req <= p; oc_req <= o; fault_req <= f;
    repeat (10) @(posedge aclk);
  endtask

  localparam logic [1:0] OK = rhpc_pkg::RESP_OKAY;

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    plug_req = 1'b0; oc_req = 1'b0; fault_req = 1'b0;
    fail_count = 0; samples_checked = 0; cycles = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0000_0000, OK);
    pins(1'b1, 1'b0, 1'b0);
    rd(8'h00, 32'h0001_0001, OK);
    wr(8'h00, 32'h0000_0000, 4'hF, OK);
    rd(8'h00, 32'h0001_0001, OK);
    wr(8'h00, 32'h0001_0000, 4'h4, OK);
    rd(8'h00, 32'h0000_0001, OK);
    $display("test connect and clear done");
    wr(8'h00, 32'h0000_0010, 4'h1, OK);
    wait_end(1);
    `CHK(rst_len, 40)
    rd(8'h00, 32'h0010_0003, OK);
    `CHK(port_enabled, 1'b1)
    wr(8'h00, 32'h0010_0000, 4'h4, OK);
    $display("test port reset done");
    wr(8'h00, 32'h0000_0004, 4'h1, OK);
    rd(8'h00, 32'h0000_0007, OK);
    `CHK(port_suspended, 1'b1)
    wr(8'h00, 32'h0000_0008, 4'h1, OK);
    wait_end(2);
    `CHK(res_len, 30)
    `CHK(eop_len, 54)
    rd(8'h00, 32'h0000_0007, OK);
    repeat (25) @(posedge aclk);
    rd(8'h00, 32'h0004_0003, OK);
    `CHK(port_suspended, 1'b0)
    wr(8'h00, 32'h0000_0010, 4'h1, OK);
    wait_end(1);
    rd(8'h00, 32'h0010_0003, OK);
    wr(8'h00, 32'h0010_0000, 4'h4, OK);
    $display("test resume done");
    pins(1'b1, 1'b1, 1'b0);
    rd(8'h00, 32'h0008_000B, OK);
    wr(8'h00, 32'h0008_0000, 4'h4, OK);
    pins(1'b1, 1'b0, 1'b0);
    rd(8'h00, 32'h0008_0003, OK);
    wr(8'h00, 32'h0008_0000, 4'h4, OK);
    wr(8'h04, 32'h0000_0000, 4'h1, OK);
    pins(1'b1, 1'b1, 1'b0);
    rd(8'h00, 32'h0000_0003, OK);
    pins(1'b1, 1'b0, 1'b0);
    wr(8'h04, 32'h0000_0001, 4'h1, OK);
    $display("test overcurrent done");
    wr(8'h00, 32'h0000_0001, 4'h1, OK);
    rd(8'h00, 32'h0000_0001, OK);
    wr(8'h00, 32'h0000_0002, 4'h1, OK);
    rd(8'h00, 32'h0000_0003, OK);
    pins(1'b1, 1'b0, 1'b1);
    rd(8'h00, 32'h0002_0001, OK);
    pins(1'b1, 1'b0, 1'b0);
    wr(8'h00, 32'h0002_0000, 4'h4, OK);
    $display("test enable lost done");
    pins(1'b0, 1'b0, 1'b0);
    rd(8'h00, 32'h0001_0000, OK);
    wr(8'h00, 32'h0001_0000, 4'h4, OK);
    wr(8'h00, 32'h0000_0010, 4'h1, OK);
    rd(8'h00, 32'h0001_0000, OK);
    $display("test disconnect done");
    rd(8'h40, 32'h0000_0000, rhpc_pkg::RESP_SLVERR);
    wr(8'h40, 32'h0000_0001, 4'hF, rhpc_pkg::RESP_SLVERR);
    $display("test unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0000_0000, OK);
    $display("test second reset done");
    close_out();
  end
endmodule
